// ### core/abrs_pkg.sv
// Shared constants and types for the AXI block RAM slave.
package abrs_pkg;

    // ********************************************************************
    // Bus and memory geometry
    // ********************************************************************
    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;
    localparam int ID_W = 4;
    localparam int LEN_W = 8;
    localparam int STRB_W = DATA_W / 8;
    localparam int MEM_DEPTH = 1024;
    localparam int IDX_W = 10;
    localparam int IDX_LO = 2;
    localparam int FIFO_DEPTH = 8;
    localparam int LVL_W = 4;
    localparam int FIFO_W = ID_W + 1 + DATA_W;

    // ********************************************************************
    // Field encodings and reset values
    // ********************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] BURST_WRAP = 2'h2;
    localparam logic [LEN_W-1:0] LEN_SINGLE = 8'h00;
    localparam logic [LVL_W-1:0] FIFO_DEPTH_L = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
    localparam logic [ID_W-1:0] ID_RST = 4'h0;

    // ********************************************************************
    // Configurations and state machines
    // ********************************************************************
    typedef enum logic [3:0] {
        MODE_MEM_FULL = 4'h1,
        MODE_MEM_LITE = 4'h2,
        MODE_PER_FULL = 4'h4,
        MODE_PER_LITE = 4'h8
    } abrs_mode_e;

    typedef enum logic [2:0] {
        W_IDLE = 3'h1,
        W_DATA = 3'h2,
        W_RESP = 3'h4
    } abrs_wstate_e;

    typedef enum logic [1:0] {
        R_IDLE = 2'h1,
        R_BURST = 2'h2
    } abrs_rstate_e;

endpackage

// ### core/abrs_fifo_if.sv
// Push and pop signals of the read data FIFO.
`timescale 1ns/1ps
interface abrs_fifo_if #(
    parameter int W = 8,
    parameter int LW = 4
);
    logic push_valid;
    logic push_ready;
    logic [W-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [W-1:0] pop_data;
    logic [LW-1:0] level;

    modport store (
        input push_valid, push_data, pop_ready,
        output push_ready, pop_valid, pop_data, level
    );
    modport user (
        output push_valid, push_data, pop_ready,
        input push_ready, pop_valid, pop_data, level
    );
endinterface

// ### core/abrs_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module abrs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Push and pop ports.
    abrs_fifo_if.store f
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] DEPTH_C = DEPTH[PW:0];
    localparam logic [PW:0] ONE_C = {{PW{1'b0}}, 1'b1};

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_ff;
    logic [PW-1:0] rd_ptr_ff;
    logic [PW:0] cnt_ff;
    wire push_en = f.push_valid && f.push_ready;
    wire pop_en = f.pop_valid && f.pop_ready;

    // Full and empty follow the occupancy count exactly.
    assign f.push_ready = (cnt_ff != DEPTH_C);
    assign f.pop_valid = (cnt_ff != '0);
    assign f.pop_data = mem[rd_ptr_ff];
    assign f.level = cnt_ff;

    // Storage is written on every accepted push.
    always_ff @(posedge clk_i) begin
        if (push_en) begin
            mem[wr_ptr_ff] <= f.push_data;
        end
    end

    // Pointers wrap naturally since the depth is a power of two.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ptr_ff <= push_en ? wr_ptr_ff + ONE_C[PW-1:0] : wr_ptr_ff;
            rd_ptr_ff <= pop_en ? rd_ptr_ff + ONE_C[PW-1:0] : rd_ptr_ff;
            cnt_ff <= cnt_ff + (push_en ? ONE_C : '0) - (pop_en ? ONE_C : '0);
        end
    end
endmodule

// ### core/abrs_top.sv
// AXI4 / AXI4-Lite slave in front of a simple dual-port block RAM.
`timescale 1ns/1ps
module abrs_top #(
    parameter abrs_pkg::abrs_mode_e MODE = abrs_pkg::MODE_MEM_FULL
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Write address channel.
    input wire logic [abrs_pkg::ID_W-1:0] awid_i,
    input wire logic [abrs_pkg::ADDR_W-1:0] awaddr_i,
    input wire logic [abrs_pkg::LEN_W-1:0] awlen_i,
    input wire logic [2:0] awsize_i,
    input wire logic [1:0] awburst_i,
    input wire logic awvalid_i,
    output logic awready_o,
    // Write data channel.
    input wire logic [abrs_pkg::DATA_W-1:0] wdata_i,
    input wire logic [abrs_pkg::STRB_W-1:0] wstrb_i,
    input wire logic wlast_i,
    input wire logic wvalid_i,
    output logic wready_o,
    // Write response channel.
    output logic [abrs_pkg::ID_W-1:0] bid_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    // Read address channel.
    input wire logic [abrs_pkg::ID_W-1:0] arid_i,
    input wire logic [abrs_pkg::ADDR_W-1:0] araddr_i,
    input wire logic [abrs_pkg::LEN_W-1:0] arlen_i,
    input wire logic [2:0] arsize_i,
    input wire logic [1:0] arburst_i,
    input wire logic arvalid_i,
    output logic arready_o,
    // Read data channel.
    output logic [abrs_pkg::ID_W-1:0] rid_o,
    output logic [abrs_pkg::DATA_W-1:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rlast_o,
    output logic rvalid_o,
    input wire logic rready_i
);
    import abrs_pkg::*;

    // ********************************************************************
    // Configuration decode
    // ********************************************************************

    // Lite modes force single beats; only the full memory mode follows wrap bursts.
    wire is_lite = (MODE == MODE_MEM_LITE) || (MODE == MODE_PER_LITE);
    wire wrap_ok = (MODE == MODE_MEM_FULL);

    // Storage is 1024 words of 32 bits, a 4 KB range for every mode.
    logic [DATA_W-1:0] mem [MEM_DEPTH];

    // Transfer size is not used: narrow writes rely on the byte strobes.
    wire unused_size = ^{awsize_i, arsize_i, wlast_i};

    // Next word index: wraps inside the aligned line for wrap bursts.
    function automatic logic [IDX_W-1:0] next_idx(
        input logic [IDX_W-1:0] idx,
        input logic [LEN_W-1:0] len,
        input logic wrap
    );
        logic [IDX_W-1:0] inc;
        logic [IDX_W-1:0] msk;
        inc = idx + {{(IDX_W-1){1'b0}}, 1'b1};
        msk = {{(IDX_W-LEN_W){1'b0}}, len};
        if (wrap) begin
            next_idx = (idx & ~msk) | (inc & msk);
        end else begin
            next_idx = inc;
        end
    endfunction

    // ********************************************************************
    // Write state machine
    // ********************************************************************
    abrs_wstate_e w_state_ff;
    abrs_wstate_e nxt_w_state;
    logic [IDX_W-1:0] w_idx_ff;
    logic [LEN_W-1:0] w_len_ff;
    logic [LEN_W-1:0] w_cnt_ff;
    logic w_wrap_ff;
    logic [ID_W-1:0] w_id_ff;
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;

    // Handshake terms on the write channels.
    wire aw_take = awvalid_i && awready_ff;
    wire w_take = wvalid_i && wready_ff;
    wire b_done = bvalid_ff && bready_i;
    wire w_last_beat = (w_cnt_ff == w_len_ff);
    wire [LEN_W-1:0] aw_len_eff = is_lite ? LEN_SINGLE : awlen_i;
    wire aw_wrap = wrap_ok && (awburst_i == BURST_WRAP);

    // Write sequencing: address, all data beats, then one response.
    always_comb begin
        nxt_w_state = w_state_ff;
        case (w_state_ff)
            W_IDLE: begin
                if (aw_take) begin
                    nxt_w_state = W_DATA;
                end
            end
            W_DATA: begin
                if (w_take && w_last_beat) begin
                    nxt_w_state = W_RESP;
                end
            end
            W_RESP: begin
                if (b_done) begin
                    nxt_w_state = W_IDLE;
                end
            end
            default: begin
                nxt_w_state = W_IDLE;
            end
        endcase
    end

    // Channel readies and response valid are decoded from the next state.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            w_state_ff <= W_IDLE;
            awready_ff <= 1'b1;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
        end else begin
            w_state_ff <= nxt_w_state;
            awready_ff <= (nxt_w_state == W_IDLE);
            wready_ff <= (nxt_w_state == W_DATA);
            bvalid_ff <= (nxt_w_state == W_RESP);
        end
    end

    // Burst address, length, beat count and id of the write in progress.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            w_idx_ff <= '0;
            w_len_ff <= LEN_SINGLE;
            w_cnt_ff <= '0;
            w_wrap_ff <= 1'b0;
            w_id_ff <= ID_RST;
        end else if (aw_take) begin
            w_idx_ff <= awaddr_i[IDX_LO +: IDX_W];
            w_len_ff <= aw_len_eff;
            w_cnt_ff <= '0;
            w_wrap_ff <= aw_wrap;
            w_id_ff <= awid_i;
        end else if (w_take) begin
            w_idx_ff <= next_idx(w_idx_ff, w_len_ff, w_wrap_ff);
            w_cnt_ff <= w_cnt_ff + 8'h01;
        end
    end

    // ********************************************************************
    // Write port of the RAM
    // ********************************************************************

    // Each byte lane is written only where its strobe is set.
    genvar gi;
    generate
        for (gi = 0; gi < STRB_W; gi++) begin : g_lane
            always_ff @(posedge clk_i) begin
                if (w_take && wstrb_i[gi]) begin
                    mem[w_idx_ff][gi*8 +: 8] <= wdata_i[gi*8 +: 8];
                end
            end
        end
    endgenerate

    // ********************************************************************
    // Read state machine
    // ********************************************************************
    abrs_rstate_e r_state_ff;
    abrs_rstate_e nxt_r_state;
    logic [IDX_W-1:0] r_idx_ff;
    logic [LEN_W-1:0] r_len_ff;
    logic [LEN_W-1:0] r_cnt_ff;
    logic r_wrap_ff;
    logic [ID_W-1:0] r_id_ff;
    logic arready_ff;
    logic rd_pend_ff;
    logic rd_last_ff;
    logic [ID_W-1:0] rd_id_ff;
    logic [DATA_W-1:0] ram_q_ff;

    abrs_fifo_if #(.W(FIFO_W), .LW(LVL_W)) rfifo ();

    // A RAM read is issued only when the FIFO can take it with the one in flight.
    wire ar_take = arvalid_i && arready_ff;
    wire [LVL_W-1:0] fill = rfifo.level + {{(LVL_W-1){1'b0}}, rd_pend_ff};
    wire room = rfifo.push_ready && (fill < FIFO_DEPTH_L);
    wire issue = (r_state_ff == R_BURST) && room;
    wire r_last_issue = (r_cnt_ff == r_len_ff);
    wire [LEN_W-1:0] ar_len_eff = is_lite ? LEN_SINGLE : arlen_i;
    wire ar_wrap = wrap_ok && (arburst_i == BURST_WRAP);

    // Read sequencing runs independently of the write side.
    always_comb begin
        nxt_r_state = r_state_ff;
        case (r_state_ff)
            R_IDLE: begin
                if (ar_take) begin
                    nxt_r_state = R_BURST;
                end
            end
            R_BURST: begin
                if (issue && r_last_issue) begin
                    nxt_r_state = R_IDLE;
                end
            end
            default: begin
                nxt_r_state = R_IDLE;
            end
        endcase
    end

    // Read address ready is a flip-flop, high whenever the machine idles.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r_state_ff <= R_IDLE;
            arready_ff <= 1'b1;
        end else begin
            r_state_ff <= nxt_r_state;
            arready_ff <= (nxt_r_state == R_IDLE);
        end
    end

    // Burst address, length, issue count and id of the read in progress.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r_idx_ff <= '0;
            r_len_ff <= LEN_SINGLE;
            r_cnt_ff <= '0;
            r_wrap_ff <= 1'b0;
            r_id_ff <= ID_RST;
        end else if (ar_take) begin
            r_idx_ff <= araddr_i[IDX_LO +: IDX_W];
            r_len_ff <= ar_len_eff;
            r_cnt_ff <= '0;
            r_wrap_ff <= ar_wrap;
            r_id_ff <= arid_i;
        end else if (issue) begin
            r_idx_ff <= next_idx(r_idx_ff, r_len_ff, r_wrap_ff);
            r_cnt_ff <= r_cnt_ff + 8'h01;
        end
    end

    // ********************************************************************
    // Read port of the RAM and data FIFO
    // ********************************************************************

    // Registered read port; its result lands in the FIFO one cycle later.
    always_ff @(posedge clk_i) begin
        if (issue) begin
            ram_q_ff <= mem[r_idx_ff];
        end
    end

    // Tag that travels with each word read out of the RAM.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_pend_ff <= 1'b0;
            rd_last_ff <= 1'b0;
            rd_id_ff <= ID_RST;
        end else begin
            rd_pend_ff <= issue;
            rd_last_ff <= r_last_issue;
            rd_id_ff <= r_id_ff;
        end
    end

    assign rfifo.push_valid = rd_pend_ff;
    assign rfifo.push_data = {rd_id_ff, rd_last_ff, ram_q_ff};

    abrs_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_rfifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .f(rfifo.store)
    );

    // ********************************************************************
    // Read data output stage
    // ********************************************************************
    logic rvalid_ff;
    logic rlast_ff;
    logic [ID_W-1:0] rid_ff;
    logic [DATA_W-1:0] rdata_ff;

    // The stage reloads when empty or when the current beat is taken.
    wire out_free = !rvalid_ff || rready_i;
    assign rfifo.pop_ready = out_free;
    wire load = out_free && rfifo.pop_valid;

    // Output beat: next word on acceptance, valid dropped when none is ready.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rvalid_ff <= 1'b0;
            rlast_ff <= 1'b0;
            rid_ff <= ID_RST;
            rdata_ff <= '0;
        end else if (out_free) begin
            rvalid_ff <= rfifo.pop_valid;
            if (load) begin
                {rid_ff, rlast_ff, rdata_ff} <= rfifo.pop_data;
            end
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************

    // Every output is a flip-flop or a constant response code.
    assign awready_o = awready_ff;
    assign wready_o = wready_ff;
    assign bid_o = w_id_ff;
    assign bresp_o = RESP_OKAY;
    assign bvalid_o = bvalid_ff;
    assign arready_o = arready_ff;
    assign rid_o = rid_ff;
    assign rdata_o = rdata_ff;
    assign rresp_o = RESP_OKAY;
    assign rlast_o = rlast_ff;
    assign rvalid_o = rvalid_ff;

    // Only the parity of unused inputs is formed; nothing reads it further.
    wire unused_ok = unused_size || !unused_size || (ADDR_RST == '0);
endmodule

// ### verification/abrs_chk.sv
// Concurrent protocol checks on the ports of the AXI block RAM slave.
`timescale 1ns/1ps
module abrs_chk (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Write channels.
    input wire logic awvalid_i,
    input wire logic awready_o,
    input wire logic wvalid_i,
    input wire logic wready_o,
    input wire logic [abrs_pkg::ID_W-1:0] bid_o,
    input wire logic bvalid_o,
    input wire logic bready_i,
    // Read channels.
    input wire logic arvalid_i,
    input wire logic arready_o,
    input wire logic [abrs_pkg::ID_W-1:0] rid_o,
    input wire logic [abrs_pkg::DATA_W-1:0] rdata_o,
    input wire logic rlast_o,
    input wire logic rvalid_o,
    input wire logic rready_i
);
    import abrs_pkg::*;

    // All checks share the bus clock and are quiet while reset is low.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // Handshake events that the checks below are built from.
    sequence s_aw_take; awvalid_i && awready_o; endsequence
    sequence s_b_take; bvalid_o && bready_i; endsequence
    sequence s_ar_take; arvalid_i && arready_o; endsequence
    sequence s_w_last; (wvalid_i && wready_o) ##1 !wready_o; endsequence

    chk_aw_reopen: assert property (s_b_take |=> awready_o)
        else $error("write address ready did not return after the response");
    chk_aw_busy: assert property (s_aw_take |=> !awready_o && wready_o)
        else $error("write data ready missing after address capture");
    chk_w_needs_addr: assert property ($rose(wready_o) |-> $past(awvalid_i && awready_o))
        else $error("write data ready rose without a captured address");
    chk_w_idle_low: assert property (awready_o |-> !wready_o)
        else $error("write data ready high while idle");
    chk_b_follows: assert property (s_w_last |-> bvalid_o)
        else $error("response missing after the final write beat");
    chk_b_after_beat: assert property ($rose(bvalid_o) |-> $past(wvalid_i && wready_o))
        else $error("response raised without a final accepted beat");
    chk_b_hold: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bid_o))
        else $error("response dropped or changed before acceptance");
    chk_b_once: assert property (s_b_take |=> !bvalid_o)
        else $error("response repeated after acceptance");
    chk_ar_busy: assert property (s_ar_take |=> !arready_o)
        else $error("read address ready stayed high after capture");
    chk_r_latency: assert property (s_ar_take |-> ##[3:300] rvalid_o)
        else $error("read data never arrived");
    chk_r_stall: assert property (rvalid_o && !rready_i |=>
        rvalid_o && $stable(rdata_o) && $stable(rid_o) && $stable(rlast_o))
        else $error("read beat changed while stalled");
endmodule

bind abrs_top abrs_chk chk_u (.clk_i, .rst_n_i, .awvalid_i, .awready_o, .wvalid_i, .wready_o, .bid_o, .bvalid_o,
    .bready_i, .arvalid_i, .arready_o, .rid_o, .rdata_o, .rlast_o, .rvalid_o, .rready_i);

// ### verification/abrs_master_model.sv
// Behavioural AXI4 master that drives the slave's five channels.
`timescale 1ns/1ps
module abrs_master_model (
    // Clock, reset and read throttle control.
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic stall_i,
    // Write address and data channels.
    output logic [abrs_pkg::ID_W-1:0] awid_o,
    output logic [abrs_pkg::ADDR_W-1:0] awaddr_o,
    output logic [abrs_pkg::LEN_W-1:0] awlen_o,
    output logic [1:0] awburst_o,
    output logic awvalid_o,
    input wire logic awready_i,
    output logic [abrs_pkg::DATA_W-1:0] wdata_o,
    output logic [abrs_pkg::STRB_W-1:0] wstrb_o,
    output logic wlast_o,
    output logic wvalid_o,
    input wire logic wready_i,
    // Write response channel.
    output logic bready_o,
    input wire logic bvalid_i,
    // Read channels.
    output logic [abrs_pkg::ID_W-1:0] arid_o,
    output logic [abrs_pkg::ADDR_W-1:0] araddr_o,
    output logic [abrs_pkg::LEN_W-1:0] arlen_o,
    output logic [1:0] arburst_o,
    output logic arvalid_o,
    input wire logic arready_i,
    output logic rready_o
);
    import abrs_pkg::*;

    // Nothing is requested at time zero.
    initial begin
        {awvalid_o, wvalid_o, wlast_o, arvalid_o, bready_o} = '0;
        {awid_o, awaddr_o, awlen_o, wdata_o, wstrb_o, arid_o, araddr_o, arlen_o} = '0;
        {awburst_o, arburst_o} = 4'h5;
    end

    // Read data acceptance, throttled at random while stalling is asked for.
    always @(posedge clk_i) begin
        #1;
        rready_o = stall_i ? 1'($urandom_range(1)) : 1'b1;
    end

    // One write: address, every beat, then the response; each held until its ready is sampled.
    task automatic write_burst(input logic [ID_W-1:0] id, input logic [ADDR_W-1:0] addr,
        input logic [LEN_W-1:0] len, input logic [1:0] bst, input logic [STRB_W-1:0] strb,
        input logic [DATA_W-1:0] wd [256], input bit early, input int bwait, output bit ok);
        int n;
        @(posedge clk_i);
        #1 {wstrb_o, wdata_o, wlast_o, wvalid_o} = {strb, wd[0], len == 8'h00, early};
        // Early data stands two cycles with no address before the address is offered.
        if (early) begin
            repeat (2) @(posedge clk_i);
            #1;
        end
        {awid_o, awaddr_o, awlen_o, awburst_o, awvalid_o} = {id, addr, len, bst, 1'b1};
        n = 0;
        do @(posedge clk_i); while (!awready_i && ++n < 2000);
        ok = n < 2000;
        #1 awvalid_o = 1'b0;
        {awaddr_o, awlen_o} = ~{addr, len};
        for (int i = 0; i <= int'(len); i++) begin
            {wdata_o, wlast_o, wvalid_o} = {wd[i], i == int'(len), 1'b1};
            n = 0;
            do @(posedge clk_i); while (!wready_i && ++n < 2000);
            ok &= n < 2000;
            #1;
        end
        {wdata_o, wlast_o, wvalid_o} = {~wdata_o, 2'h0};
        repeat (bwait) @(posedge clk_i);
        #1 bready_o = 1'b1;
        n = 0;
        do @(posedge clk_i); while (!bvalid_i && ++n < 2000);
        ok &= n < 2000;
        #1 bready_o = 1'b0;
    endtask

    // One read request; the beats are taken by the throttle process above.
    task automatic read_burst(input logic [ID_W-1:0] id, input logic [ADDR_W-1:0] addr,
        input logic [LEN_W-1:0] len, input logic [1:0] bst, output bit ok);
        int n;
        @(posedge clk_i);
        #1 {arid_o, araddr_o, arlen_o, arburst_o, arvalid_o} = {id, addr, len, bst, 1'b1};
        n = 0;
        do @(posedge clk_i); while (!arready_i && ++n < 2000);
        ok = n < 2000;
        #1 arvalid_o = 1'b0;
        {araddr_o, arlen_o} = ~{addr, len};
    endtask
endmodule

// ### verification/testbench.sv
// Self-checking testbench for the AXI block RAM slave.
`timescale 1ns/1ps
module testbench;
    import abrs_pkg::*;

    logic clk_i, rst_n_i, stall;
    logic [ID_W-1:0] awid_i, arid_i, bid_o, rid_o;
    logic [ADDR_W-1:0] awaddr_i, araddr_i;
    logic [LEN_W-1:0] awlen_i, arlen_i;
    logic [1:0] awburst_i, arburst_i, bresp_o, rresp_o;
    logic [DATA_W-1:0] wdata_i, rdata_o;
    logic [STRB_W-1:0] wstrb_i;
    logic awvalid_i, awready_o, wlast_i, wvalid_i, wready_o, bvalid_o, bready_i;
    logic arvalid_i, arready_o, rlast_o, rvalid_o, rready_i;
    logic [DATA_W-1:0] ref_mem [MEM_DEPTH];
    logic [DATA_W-1:0] wd [256];
    logic [ID_W+2+DATA_W:0] r_q [$];
    logic [ID_W+1:0] b_q [$];
    int miscompares, cmp_count;

    abrs_top #(.MODE(MODE_MEM_FULL)) dut_u (.clk_i, .rst_n_i, .awid_i, .awaddr_i, .awlen_i, .awsize_i(3'h2),
        .awburst_i, .awvalid_i, .awready_o, .wdata_i, .wstrb_i, .wlast_i, .wvalid_i, .wready_o, .bid_o, .bresp_o,
        .bvalid_o, .bready_i, .arid_i, .araddr_i, .arlen_i, .arsize_i(3'h2), .arburst_i, .arvalid_i, .arready_o,
        .rid_o, .rdata_o, .rresp_o, .rlast_o, .rvalid_o, .rready_i);

    abrs_master_model master_u (.clk_i, .rst_n_i, .stall_i(stall), .awid_o(awid_i), .awaddr_o(awaddr_i),
        .awlen_o(awlen_i), .awburst_o(awburst_i), .awvalid_o(awvalid_i), .awready_i(awready_o), .wdata_o(wdata_i),
        .wstrb_o(wstrb_i), .wlast_o(wlast_i), .wvalid_o(wvalid_i), .wready_i(wready_o), .bready_o(bready_i),
        .bvalid_i(bvalid_o), .arid_o(arid_i), .araddr_o(araddr_i), .arlen_o(arlen_i), .arburst_o(arburst_i),
        .arvalid_o(arvalid_i), .arready_i(arready_o), .rready_o(rready_i));

    // Free-running 200 MHz bus clock.
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Word index of beat i, following incrementing or wrapping order.
    function automatic int widx(input int idx, input int len, input logic [1:0] bst, input int i);
        if (bst == BURST_WRAP) begin
            return idx - idx % (len + 1) + (idx % (len + 1) + i) % (len + 1);
        end
        return (idx + i) % MEM_DEPTH;
    endfunction

    // Counts one comparison and reports a mismatch at once.
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic complete_run(input bit hang);
        if (hang) miscompares++;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Writes one burst of random words and notes the memory update and the response.
    task automatic wr(input logic [ID_W-1:0] id, input int idx, input int len, input logic [1:0] bst,
        input logic [STRB_W-1:0] strb, input bit early, input int bwait);
        logic [DATA_W-1:0] m;
        bit ok;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        for (int i = 0; i <= len; i++) begin
            wd[i] = $urandom();
            ref_mem[widx(idx, len, bst, i)] = (ref_mem[widx(idx, len, bst, i)] & ~m) | (wd[i] & m);
        end
        b_q.push_back({id, RESP_OKAY});
        master_u.write_burst(id, ADDR_W'(idx * 4), LEN_W'(len), bst, strb, wd, early, bwait, ok);
        if (!ok) complete_run(1'b1);
    endtask

    // Requests one read burst and notes every expected beat.
    task automatic rd(input logic [ID_W-1:0] id, input int idx, input int len, input logic [1:0] bst);
        bit ok;
        for (int i = 0; i <= len; i++) r_q.push_back({id, i == len, RESP_OKAY, ref_mem[widx(idx, len, bst, i)]});
        master_u.read_burst(id, ADDR_W'(idx * 4), LEN_W'(len), bst, ok);
        if (!ok) complete_run(1'b1);
    endtask

    // Waits, bounded, until every noted result has been seen.
    task automatic finish_test(input string name);
        for (int n = 0; n < 3000 && r_q.size() + b_q.size() > 0; n++) @(posedge clk_i);
        if (r_q.size() + b_q.size() > 0) complete_run(1'b1);
        $display("Test %s finished", name);
    endtask

    // Result monitor: every accepted beat or response is matched against the oldest note.
    always @(posedge clk_i) begin
        if (rst_n_i === 1'b1 && rvalid_o === 1'b1 && rready_i === 1'b1) begin
            check(64'({rid_o, rlast_o, rresp_o, rdata_o}),
                r_q.size() > 0 ? 64'(r_q.pop_front()) : {64{1'bx}});
        end
        if (rst_n_i === 1'b1 && bvalid_o === 1'b1 && bready_i === 1'b1) begin
            check(64'({bid_o, bresp_o}), b_q.size() > 0 ? 64'(b_q.pop_front()) : {64{1'bx}});
        end
    end

    // Main sequence: reset, then the scenarios in turn.
    initial begin
        {rst_n_i, stall, miscompares, cmp_count} = '0;
        void'($urandom(63));
        repeat (5) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        // Single beats: address first, data first with a late response, then a partial lane write.
        wr(4'h1, 10, 0, 2'h1, 4'hF, 1'b0, 0);
        wr(4'h2, 11, 0, 2'h1, 4'hF, 1'b1, 4);
        wr(4'h3, 10, 0, 2'h1, 4'h5, 1'b1, 0);
        rd(4'h4, 10, 0, 2'h1);
        rd(4'h5, 11, 0, 2'h1);
        finish_test("single");
        // Longest burst across the top of memory, read back under random stalls.
        wr(4'h6, 900, 255, 2'h1, 4'hF, 1'b0, 1);
        stall = 1'b1;
        rd(4'h7, 900, 255, 2'h1);
        finish_test("burst");
        // Wrapping bursts of 2, 4, 8 and 16 beats starting at the last word of the line.
        for (int k = 1; k < 16; k = 2 * k + 1) begin
            wr(4'h8, 64 + k, k, BURST_WRAP, 4'hF, 1'b0, 0);
            rd(4'h9, 64 + k, k, BURST_WRAP);
        end
        finish_test("wrap");
        // A write and a read running side by side, then the written words read back.
        fork
            wr(4'hA, 300, 31, 2'h1, 4'hF, 1'b0, 2);
            rd(4'hB, 900, 63, 2'h1);
        join
        rd(4'hC, 300, 31, 2'h1);
        finish_test("concurrent");
        complete_run(1'b0);
    end
endmodule
